// ==== hw/pin_drive_mode_port.sv ====
// eight-pin port: drive mode decode, pin state read and pin interrupts
//
// Operation
// - every pin has its own three bit drive mode field
// - mode 0 disables output driver and digital input buffer
// - after reset every pin sits in mode 0
// - mode 1 never drives, input buffer enabled
// - modes 2, 3 mix resistive and strong drive per data value, 7 pulls up or down only
// - mode 4 drives low only, 5 high only, 6 both strongly
// - decode uses latch bit, or digital array signal when bypassed
// - pin state read is separate and leaves the latch untouched
// - each pin interrupts on rising, falling, both or no edge
// - all pin events of the port merge into one request line
// - interrupt logic detects edges only, never levels
// - registers reachable as port-wide bit planes or per-pin bytes
// - regulated special pins lose the resistive pulls
// - usb pad pins offer only push-pull output drive
// - per pin slew selection for digital output drive
// - each event sets its flag bit; unmasked flags raise the port request
// - bidirectional pins 0 to 5 follow one of 16 routed output enables, pins 6 and 7 enable 0
//
// Design decisions made here: the address map and the address-and-strobe port.
module pin_drive_mode_port
    import pin_port_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] array_data_in,
    input wire logic [15:0] aux_oe_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic [7:0] pull_up_out,
    output logic [7:0] pull_down_out,
    output logic [7:0] input_buf_en_out,
    output logic [7:0] slew_select_out,
    output logic [7:0] pin_state_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // all port state; sync1..sync3 are the pin sampling stages
    typedef struct packed {
        logic [7:0] port_output_latch;
        logic [7:0] dm0;
        logic [7:0] dm1;
        logic [7:0] dm2;
        logic [7:0] output_bypass_select;
        logic [7:0] slew_select;
        logic [7:0] bidirectional_enable;
        logic [7:0] regulated;
        logic [7:0] edge_lo;
        logic [7:0] edge_hi;
        logic [7:0] pin_interrupt_flags;
        logic [7:0] int_mask;
        logic [31:0] oe_sel;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] rdata;
    } port_state_s;

    port_state_s st_r;
    port_state_s st_nxt;

    // drive decode result for one pin: enable, value, pulls and
    // input buffer, one field per pad control output
    typedef struct packed {
        logic oe;
        logic value;
        logic pull_up;
        logic pull_down;
        logic ibuf;
    } drive_s;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // drive mode decode for one pin: strong enable, value, pulls
    // and input buffer, shared by every pin
    function automatic drive_s decode_drive(
        input logic [2:0] mode,
        input logic data,
        input logic regulated,
        input logic usb_pad
    );
        drive_s d;
        drive_mode_e m;
        m = drive_mode_e'(mode);
        d = '0;
        d.value = data;
        d.ibuf = (m != DM_ANALOG_HIZ);
        unique case (m)
            DM_ANALOG_HIZ: d.oe = 1'b0;
            DM_DIGITAL_HIZ: d.oe = 1'b0;
            DM_RES_UP:
            begin
                d.oe = ~data;
                d.pull_up = data;
            end
            DM_RES_DOWN:
            begin
                d.oe = data;
                d.pull_down = ~data;
            end
            DM_OD_LOW: d.oe = ~data;
            DM_OD_HIGH: d.oe = data;
            DM_STRONG: d.oe = 1'b1;
            DM_RES_UP_DOWN:
            begin
                d.oe = 1'b0;
                d.pull_up = data;
                d.pull_down = ~data;
            end
        endcase
        // pulls are cut on a regulated special pin
        if (regulated)
        begin
            d.pull_up = 1'b0;
            d.pull_down = 1'b0;
        end
        // usb pads turn every driving mode into push-pull
        if (usb_pad && (mode > 3'h1))
        begin
            d.oe = 1'b1;
            d.pull_up = 1'b0;
            d.pull_down = 1'b0;
        end
        return d;
    endfunction : decode_drive

    // write-one-to-clear with set winning over clear, so an edge
    // beside the clearing write is never lost
    function automatic logic [7:0] flag_update(
        input logic [7:0] flags,
        input logic [7:0] set_bits,
        input logic [7:0] clr_bits
    );
        return (flags & ~clr_bits) | set_bits;
    endfunction : flag_update

    // address falls in the per-pin byte window
    function automatic logic in_pin_view(input logic [5:0] addr);
        return addr[5:3] == OFS_PIN_VIEW_BASE[5:3];
    endfunction : in_pin_view

    // pulls are only cut on a special pin in regulated output
    function automatic logic pull_cut(
        input int pin,
        input logic [7:0] regulated_bits
    );
        return regulated_bits[pin] & SPECIAL_IO_PINS[pin];
    endfunction : pull_cut

    // ------------------------------------------------------------
    // combinational view of pins
    // ------------------------------------------------------------
    // per pin decode results and edge events
    logic [7:0] drive_data;
    logic [7:0] aux_oe_pick;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] events;
    drive_s pin_drive [PIN_COUNT];

    // per pin decode with bypass and bidirectional control; a pin
    // left in analog mode keeps its buffer off even if bidirectional
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            drive_data[i] = st_r.output_bypass_select[i] ?
                array_data_in[i] : st_r.port_output_latch[i];
            // pins 6 and 7 have no select byte and follow enable 0
            aux_oe_pick[i] = aux_oe_in[st_r.oe_sel[i*4 +: 4]];
            if (st_r.bidirectional_enable[i] && !aux_oe_pick[i]
                && ({st_r.dm2[i], st_r.dm1[i], st_r.dm0[i]} != 3'h0))
                pin_drive[i] = decode_drive(3'(DM_DIGITAL_HIZ),
                    drive_data[i], pull_cut(i, st_r.regulated),
                    USB_PAD_PINS[i]);
            else
                pin_drive[i] = decode_drive({st_r.dm2[i], st_r.dm1[i],
                    st_r.dm0[i]}, drive_data[i],
                    pull_cut(i, st_r.regulated),
                    USB_PAD_PINS[i]);
        end
    end

    // edge detection on synchronised inputs only; sync3 is the last
    // sample of sync2, so each transition counts for one cycle
    always_comb
    begin
        rise = st_r.sync2 & ~st_r.sync3;
        fall = ~st_r.sync2 & st_r.sync3;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            // edge code is {hi plane, lo plane}
            unique case ({st_r.edge_hi[i], st_r.edge_lo[i]})
                EDGE_NONE: events[i] = 1'b0;
                EDGE_RISE: events[i] = rise[i];
                EDGE_FALL: events[i] = fall[i];
                EDGE_BOTH: events[i] = rise[i] | fall[i];
            endcase
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // write decode and helpers of the next state logic
    logic wr_port;
    logic wr_pin;
    logic [2:0] pin_idx;
    logic [7:0] w1c;
    logic [7:0] pin_state_gated;

    // map: 00 latch, 01 pin state (read only), 02..04 mode planes,
    // 05 bypass, 06 slew, 07 bidirectional, 08 regulated, 09/0a edge
    // planes, 0b flags, 0c mask, 0d..0f enable selects, 10..17 pin
    // bytes, all else reads zero; pin byte: b0 latch, b3:1 mode,
    // b4 bypass, b5 slew, b6 bidirectional, b7 pin state
    always_comb
    begin
        st_nxt = st_r;
        wr_port = reg_wr_in && (reg_addr_in < OFS_PIN_VIEW_BASE);
        wr_pin = reg_wr_in && in_pin_view(reg_addr_in);
        pin_idx = reg_addr_in[2:0];
        w1c = '0;
        for (int i = 0; i < PIN_COUNT; i++)
            pin_state_gated[i] = st_r.sync2[i] & pin_drive[i].ibuf;

        // input synchroniser chain: only sync2 reads sync1, so a
        // metastable first stage never reaches the logic behind it
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;

        // port view writes, one bit per pin, four per pin in the enable selects
        if (wr_port)
        begin
            unique case (reg_addr_in)
                OFS_OUT_LATCH: st_nxt.port_output_latch = reg_wdata_in;
                OFS_DM0: st_nxt.dm0 = reg_wdata_in;
                OFS_DM1: st_nxt.dm1 = reg_wdata_in;
                OFS_DM2: st_nxt.dm2 = reg_wdata_in;
                OFS_BYPASS: st_nxt.output_bypass_select = reg_wdata_in;
                OFS_SLEW: st_nxt.slew_select = reg_wdata_in;
                OFS_BIDIR: st_nxt.bidirectional_enable = reg_wdata_in;
                OFS_REGULATED: st_nxt.regulated = reg_wdata_in;
                OFS_EDGE_LO: st_nxt.edge_lo = reg_wdata_in;
                OFS_EDGE_HI: st_nxt.edge_hi = reg_wdata_in;
                OFS_INT_FLAGS: w1c = reg_wdata_in;
                OFS_INT_MASK: st_nxt.int_mask = reg_wdata_in;
                OFS_OE_SEL_BASE, OFS_OE_SEL_BASE + 6'h01,
                OFS_OE_SEL_BASE + 6'h02:
                begin
                    // each select byte holds the choices of 2 pins
                    st_nxt.oe_sel[(reg_addr_in - OFS_OE_SEL_BASE) * 8
                        +: 8] = reg_wdata_in;
                end
                // the read-only pin state lands here and changes
                // nothing
                default: ;
            endcase
        end

        // pin view write, one byte per pin; bit 7 is the read-only
        // pin state and is dropped
        if (wr_pin)
        begin
            st_nxt.port_output_latch[pin_idx] = reg_wdata_in[PV_OUT];
            st_nxt.dm0[pin_idx] = reg_wdata_in[PV_DM_LO];
            st_nxt.dm1[pin_idx] = reg_wdata_in[PV_DM_LO + 1];
            st_nxt.dm2[pin_idx] = reg_wdata_in[PV_DM_LO + 2];
            st_nxt.output_bypass_select[pin_idx] = reg_wdata_in[PV_BYP];
            st_nxt.slew_select[pin_idx] = reg_wdata_in[PV_SLW];
            st_nxt.bidirectional_enable[pin_idx] = reg_wdata_in[PV_BIE];
        end

        // interrupt flags: events set, software clears by ones; an
        // event in the cycle of a clearing write still sets its flag
        st_nxt.pin_interrupt_flags =
            flag_update(st_r.pin_interrupt_flags, events, w1c);

        // read data, valid the cycle after the read strobe and zero
        // otherwise, so stale data is never taken for fresh
        st_nxt.rdata = RST_BYTE;
        if (reg_rd_in)
        begin
            // pin byte read gathers what the pin write scatters
            if (in_pin_view(reg_addr_in))
                st_nxt.rdata = {pin_state_gated[pin_idx],
                    st_r.bidirectional_enable[pin_idx],
                    st_r.slew_select[pin_idx],
                    st_r.output_bypass_select[pin_idx],
                    st_r.dm2[pin_idx], st_r.dm1[pin_idx],
                    st_r.dm0[pin_idx],
                    st_r.port_output_latch[pin_idx]};
            else
            begin
                unique case (reg_addr_in)
                    OFS_OUT_LATCH: st_nxt.rdata = st_r.port_output_latch;
                    OFS_PIN_STATE: st_nxt.rdata = pin_state_gated;
                    OFS_DM0: st_nxt.rdata = st_r.dm0;
                    OFS_DM1: st_nxt.rdata = st_r.dm1;
                    OFS_DM2: st_nxt.rdata = st_r.dm2;
                    OFS_BYPASS: st_nxt.rdata = st_r.output_bypass_select;
                    OFS_SLEW: st_nxt.rdata = st_r.slew_select;
                    OFS_BIDIR: st_nxt.rdata = st_r.bidirectional_enable;
                    OFS_REGULATED: st_nxt.rdata = st_r.regulated;
                    OFS_EDGE_LO: st_nxt.rdata = st_r.edge_lo;
                    OFS_EDGE_HI: st_nxt.rdata = st_r.edge_hi;
                    OFS_INT_FLAGS: st_nxt.rdata = st_r.pin_interrupt_flags;
                    OFS_INT_MASK: st_nxt.rdata = st_r.int_mask;
                    OFS_OE_SEL_BASE: st_nxt.rdata = st_r.oe_sel[7:0];
                    OFS_OE_SEL_BASE + 6'h01:
                        st_nxt.rdata = st_r.oe_sel[15:8];
                    OFS_OE_SEL_BASE + 6'h02:
                        st_nxt.rdata = st_r.oe_sel[23:16];
                    default: st_nxt.rdata = RST_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // synchronous reset puts every pin in analog high impedance and
    // clears all flags, so irq_out is low from the first edge
    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            st_r <= '0;
            st_r.oe_sel <= RST_OE_SEL;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pad controls from the decode; pin_out always shows the value,
    // only pin_oe_out says whether the pad drives it
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            pin_out[i] = pin_drive[i].value;
            pin_oe_out[i] = pin_drive[i].oe;
            pull_up_out[i] = pin_drive[i].pull_up;
            pull_down_out[i] = pin_drive[i].pull_down;
            input_buf_en_out[i] = pin_drive[i].ibuf;
        end
    end

    // slew, gated pin state, read data and the port request
    assign slew_select_out = st_r.slew_select;
    assign pin_state_out = st_r.sync2 & input_buf_en_out;
    assign reg_rdata_out = st_r.rdata;
    assign irq_out = |(st_r.pin_interrupt_flags & st_r.int_mask);

endmodule : pin_drive_mode_port

// ==== include/pin_port_pkg.sv ====
// constants and types for the per-pin drive mode port
package pin_port_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 8;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int AUX_OE_COUNT = 16;
    localparam int AUX_SEL_W = 4;

    // ------------------------------------------------------------
    // pin kinds of this port
    // ------------------------------------------------------------
    localparam logic [7:0] SPECIAL_IO_PINS = 8'hc0;
    localparam logic [7:0] USB_PAD_PINS = 8'h03;

    // ------------------------------------------------------------
    // port view register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_OUT_LATCH = 6'h00;
    localparam logic [5:0] OFS_PIN_STATE = 6'h01;
    localparam logic [5:0] OFS_DM0 = 6'h02;
    localparam logic [5:0] OFS_DM1 = 6'h03;
    localparam logic [5:0] OFS_DM2 = 6'h04;
    localparam logic [5:0] OFS_BYPASS = 6'h05;
    localparam logic [5:0] OFS_SLEW = 6'h06;
    localparam logic [5:0] OFS_BIDIR = 6'h07;
    localparam logic [5:0] OFS_REGULATED = 6'h08;
    localparam logic [5:0] OFS_EDGE_LO = 6'h09;
    localparam logic [5:0] OFS_EDGE_HI = 6'h0a;
    localparam logic [5:0] OFS_INT_FLAGS = 6'h0b;
    localparam logic [5:0] OFS_INT_MASK = 6'h0c;
    localparam logic [5:0] OFS_OE_SEL_BASE = 6'h0d;
    localparam logic [5:0] OFS_PIN_VIEW_BASE = 6'h10;

    // ------------------------------------------------------------
    // pin view field positions
    // ------------------------------------------------------------
    localparam int PV_OUT = 0;
    localparam int PV_DM_LO = 1;
    localparam int PV_BYP = 4;
    localparam int PV_SLW = 5;
    localparam int PV_BIE = 6;
    localparam int PV_STATE = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_OE_SEL = 32'h0000_0000;

    // drive mode encodings
    typedef enum logic [2:0] {
        DM_ANALOG_HIZ = 3'h0,
        DM_DIGITAL_HIZ = 3'h1,
        DM_RES_UP = 3'h2,
        DM_RES_DOWN = 3'h3,
        DM_OD_LOW = 3'h4,
        DM_OD_HIGH = 3'h5,
        DM_STRONG = 3'h6,
        DM_RES_UP_DOWN = 3'h7
    } drive_mode_e;

    // edge select encodings, one bit from each edge plane
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage : pin_port_pkg

// ==== tb/pin_board_model.sv ====
// board side model: resolves each pad wire from all its drivers
module pin_board_model (
    input wire logic clk_in,
    input wire logic [7:0] drive_val_in,
    input wire logic [7:0] drive_en_in,
    input wire logic [7:0] pull_up_in,
    input wire logic [7:0] pull_down_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_r = 8'h00;

    // an undriven wire wanders every cycle
    always_ff @(posedge clk_in)
        float_r <= ~float_r;

    // strong drive wins, then board drivers, then pulls
    always_comb
    begin
        for (int y = 0; y < 8; y++)
        begin
            if (drive_en_in[y])
                level_out[y] = drive_val_in[y];
            else if (ext_en_in[y])
                level_out[y] = ext_val_in[y];
            else if (pull_up_in[y])
                level_out[y] = 1'b1;
            else if (pull_down_in[y])
                level_out[y] = 1'b0;
            else
                level_out[y] = float_r[y];
        end
    end
endmodule : pin_board_model

// ==== tb/pin_port_monitor.sv ====
// concurrent checks on the pin drive mode port boundary
module pin_port_monitor
    import pin_port_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] array_data_in,
    input wire logic [15:0] aux_oe_in,
    input wire logic [7:0] pin_oe_out,
    input wire logic [7:0] pull_up_out,
    input wire logic [7:0] pull_down_out,
    input wire logic [7:0] input_buf_en_out,
    input wire logic [7:0] pin_state_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------
    // assertions
    // -------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn_in |=>
        (pin_oe_out | pull_up_out | pull_down_out | input_buf_en_out) == 8'h00
        && !irq_out) else $error("pins not quiet after reset");
    AST_RDATA_IDLE: assert property (!reg_rd_in |=>
        reg_rdata_out == 8'h00) else $error("read data without read");
    AST_STRONG_NO_PULL: assert property (
        (pin_oe_out & (pull_up_out | pull_down_out)) == 8'h00)
        else $error("strong drive with pull");
    AST_IBUF_GATE: assert property (
        (pin_state_out & ~input_buf_en_out) == 8'h00)
        else $error("pin state with buffer off");
    AST_ANALOG_NO_DRIVE: assert property (((pin_oe_out | pull_up_out
        | pull_down_out) & ~input_buf_en_out) == 8'h00)
        else $error("analog pin drives");
    AST_USB_NO_PULL: assert property (
        ((pull_up_out | pull_down_out) & USB_PAD_PINS) == 8'h00)
        else $error("usb pad pulled");
    AST_IRQ_HOLD: assert property (irq_out && !reg_wr_in |=> irq_out)
        else $error("irq dropped without write");
    AST_DRIVE_CAUSE: assert property (!reg_wr_in ##1
        ($stable(array_data_in) && $stable(aux_oe_in)) |->
        $stable(pin_oe_out) && $stable(pull_up_out))
        else $error("drive changed without cause");

    // main scenarios reached
    COV_IRQ: cover property (irq_out);
    COV_PULLS: cover property (pull_up_out != 0 && pull_down_out != 0);
    COV_OE_RISE: cover property ($rose(pin_oe_out[2]));
endmodule : pin_port_monitor

bind pin_drive_mode_port pin_port_monitor pin_port_monitor_i (.*);

// ==== tb/test_pin_drive_mode_port.sv ====
// self-checking bench for the pin drive mode port
module test_pin_drive_mode_port
    import pin_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [5:0] reg_addr_in = 6'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] array_data_in = 8'h00;
    logic [15:0] aux_oe_in = 16'h0000;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] reg_rdata_out, pin_in, pin_out, pin_oe_out, pull_up_out;
    logic [7:0] pull_down_out, input_buf_en_out, slew_select_out;
    logic [7:0] pin_state_out, d, rg, p;
    logic irq_out;
    logic [7:0] v [8];
    logic [3:0] e, g, q;
    logic [23:0] s;
    int num_errors = 0;
    int check_count = 0;

    pin_drive_mode_port pin_drive_mode_port_i (.*);
    pin_board_model pin_board_model_i (
        .clk_in(ref_clk_in),
        .drive_val_in(pin_out),
        .drive_en_in(pin_oe_out),
        .pull_up_in(pull_up_out),
        .pull_down_in(pull_down_out),
        .ext_en_in(ext_en),
        .ext_val_in(ext_val),
        .level_out(pin_in)
    );

    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    task automatic chk(input logic [7:0] got, ex, input string what);
        check_count++;
        if (got !== ex)
        begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, ex);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] w);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= w;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] r);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        r = reg_rdata_out;
    endtask : rd

    // expected {oe, pull up, pull down, input buffer} of one pin
    function automatic logic [3:0] drv(input int y, input logic [7:0] w,
        input logic rgl, input logic a, input logic ar);
        logic [2:0] m;
        logic dv;
        logic [3:0] r;
        m = w[3:1];
        dv = w[4] ? ar : w[0];
        if (w[6] && !a && m != 3'h0)
            m = 3'h1;
        case (m)
            3'h0: r = 4'h0;
            3'h1: r = 4'h1;
            3'h2: r = dv ? 4'h5 : 4'h9;
            3'h3: r = dv ? 4'h9 : 4'h3;
            3'h4: r = dv ? 4'h1 : 4'h9;
            3'h5: r = dv ? 4'h9 : 4'h1;
            3'h6: r = 4'h9;
            default: r = dv ? 4'h5 : 4'h3;
        endcase
        if (USB_PAD_PINS[y] && m > 3'h1)
            r = 4'h9;
        if (rgl && SPECIAL_IO_PINS[y])
            r[2:1] = 2'h0;
        return r;
    endfunction : drv

    // one edge on all pins, then flag, clear and no re-trigger
    task automatic edge_step(input logic [7:0] lv, input logic [7:0] ex);
        ext_val <= lv;
        repeat (5) @(posedge ref_clk_in);
        rd(OFS_INT_FLAGS, d);
        chk(d, ex, "flags");
        chk({7'h0, irq_out}, {7'h0, |ex}, "irq");
        wr(OFS_INT_FLAGS, 8'hff);
        repeat (4) @(posedge ref_clk_in);
        rd(OFS_INT_FLAGS, d);
        chk(d, 8'h00, "retrigger");
    endtask : edge_step

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // clock and watchdog
    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        num_errors++;
        final_report();
    end

    // -------------------------------------------------
    // tests
    // -------------------------------------------------
    initial
    begin
        void'($urandom(32'hf63c));
        repeat (3) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk(pin_oe_out | pull_up_out | pull_down_out, 8'h00, "drive");
        chk(input_buf_en_out, 8'h00, "ibuf");
        rd(OFS_DM0, d);
        chk(d, RST_BYTE, "mode plane");
        rd(6'h3f, d);
        chk(d, 8'h00, "unmapped");
        wr(OFS_OUT_LATCH, 8'h5a);
        wr(OFS_PIN_STATE, 8'hff);
        ext_en <= 8'hff;
        ext_val <= 8'hff;
        rd(OFS_PIN_STATE, d);
        chk(d, 8'h00, "analog read");
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk(pin_state_out, 8'h00, "analog state");
        rd(OFS_OUT_LATCH, d);
        chk(d, 8'h5a, "latch");
        // random modes, data, bypass and routed enables
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk_in);
            array_data_in <= 8'($urandom);
            aux_oe_in <= 16'($urandom);
            rg = 8'($urandom);
            s = 24'($urandom);
            wr(OFS_REGULATED, rg);
            wr(OFS_OE_SEL_BASE, s[7:0]);
            wr(OFS_OE_SEL_BASE + 6'h01, s[15:8]);
            wr(OFS_OE_SEL_BASE + 6'h02, s[23:16]);
            for (int y = 0; y < 8; y++)
            begin
                v[y] = 8'($urandom);
                p[y] = v[y][2];
                wr(OFS_PIN_VIEW_BASE + 6'(y), v[y]);
            end
            #1;
            for (int y = 0; y < 8; y++)
            begin
                q = (y < 6) ? s[y*4 +: 4] : 4'h0;
                e = drv(y, v[y], rg[y], aux_oe_in[q], array_data_in[y]);
                g = {pin_oe_out[y], pull_up_out[y], pull_down_out[y],
                    input_buf_en_out[y]};
                chk({4'h0, g}, {4'h0, e}, "drive");
                if (e[3])
                    chk({7'h0, pin_out[y]}, {7'h0, v[y][4] ?
                        array_data_in[y] : v[y][0]}, "out");
                chk({7'h0, slew_select_out[y]}, {7'h0, v[y][5]}, "slew");
            end
            for (int y = 0; y < 8; y++)
            begin
                rd(OFS_PIN_VIEW_BASE + 6'(y), d);
                chk(d & 8'h7f, v[y] & 8'h7f, "pin view");
            end
            rd(OFS_DM1, d);
            chk(d, p, "port plane");
            rd(OFS_OE_SEL_BASE + 6'h02, d);
            chk(d, s[23:16], "select");
        end
        for (int y = 0; y < 8; y++)
            wr(OFS_PIN_VIEW_BASE + 6'(y), 8'h02);
        ext_val <= 8'($urandom);
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk(pin_state_out, ext_val, "pin state");
        rd(OFS_PIN_STATE, d);
        chk(d, ext_val, "state read");
        wr(OFS_INT_MASK, 8'hff);
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_EDGE_LO, {8{c[0]}});
            wr(OFS_EDGE_HI, {8{c[1]}});
            ext_val <= 8'h00;
            repeat (5) @(posedge ref_clk_in);
            wr(OFS_INT_FLAGS, 8'hff);
            edge_step(8'hff, {8{c[0]}});
            edge_step(8'h00, {8{c[1]}});
        end
        wr(OFS_INT_MASK, 8'h00);
        ext_val <= 8'h10;
        repeat (5) @(posedge ref_clk_in);
        #1;
        chk({7'h0, irq_out}, 8'h00, "masked irq");
        wr(OFS_INT_MASK, 8'h10);
        #1;
        chk({7'h0, irq_out}, 8'h01, "unmasked irq");
        // second reset in mid-run must clear pins, mask and request
        @(posedge ref_clk_in);
        resetn_in <= 1'b0;
        @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk({7'h0, irq_out}, 8'h00, "irq reset");
        chk(input_buf_en_out, 8'h00, "ibuf reset");
        rd(OFS_INT_MASK, d);
        chk(d, RST_BYTE, "mask reset");
        final_report();
    end
endmodule : test_pin_drive_mode_port
